//--- core/fsl_lockdown.sv
/*
 * Sector lockdown block of a serial flash: command decode, timed
 * nonvolatile update, busy status, per-sector refusal of array writes.
 * Assumes on-chip master logic on the link and array control on mclk.
 */
// Contract
// (R01) Locked sector refuses erase, program, unlock forever
// (R02) Opcode 0x35 reads lockdown status
// (R03) Only 3D 2A 7F 30 requests lockdown
// (R04) 24-bit address follows; lock its sector
// (R05) Master lowers select with clock high
// (R06) Bytes arrive most significant bit first
// (R07) Sector 0 splits into subsectors 0a, 0b
// (R08) Page and byte bits are ignored
// (R09) Master raises select after last address bit
// (R10) Select rising starts timed update, page program time
// (R11) Status bit 7 shows busy, then ready
// (R12) Master verifies after power loss, retries
// (R13) One status byte per sector, byte n
// (R14) Other sectors read FF locked, 00 open
// (R15) Register read-only, changes only by lockdown
// (R16) Sector 0 byte: C0, 30, F0 or 00
// (R17) Read opcode followed by three ignored bytes
// (R18) Status bytes out from sector 0 upward
// (R19) Byte count matches size: 4, 8, 16
// (R20) Master ignores bits past last byte
// (R21) Master raises select to end read
`default_nettype none

module fsl_lockdown
    import fsl_pkg::*;
#(
    parameter int NSECT = FSL_NSECT_DEF,
    parameter int SECT_LSB = FSL_SECT_LSB_DEF,
    parameter int SUB0_BIT = FSL_SUB0_BIT_DEF,
    parameter int PP_CYCLES = FSL_PP_CYCLES_DEF
)(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic miso,
    input wire logic op_req,
    input wire logic [FSL_ADDR_W-1:0] op_addr,
    output logic op_grant,
    output logic op_refuse,
    output logic [7:0] status_byte
);
    localparam int SW = $clog2(NSECT);
    localparam int TW = $clog2(PP_CYCLES + 1);
    localparam logic [TW-1:0] TMR_LAST = TW'(PP_CYCLES - 1);
    localparam logic [SW-1:0] SECT0 = SW'(0);

    // ==========================================================
    // Elaboration checks
    if (!(NSECT == 4 || NSECT == 8 || NSECT == 16)) // R19
    begin : g_bad_nsect
        $error("NSECT must be 4, 8 or 16");
    end
    if (SECT_LSB + SW > FSL_ADDR_W || SUB0_BIT >= SECT_LSB)
    begin : g_bad_field
        $error("sector field does not fit the address");
    end
    if (PP_CYCLES < FSL_PP_CYCLES_MIN)
    begin : g_bad_pp
        $error("PP_CYCLES too small");
    end

    // ==========================================================
    // Link side
    fsl_xfer_if #(.NSECT(NSECT)) xfer ();

    fsl_serial #(
        .NSECT(NSECT)
    ) u_serial (
        .nrst(nrst),
        .sclk(sclk),
        .chip_select_n(chip_select_n),
        .mosi(mosi),
        .miso(miso),
        .lnk(xfer.front)
    );

    // ==========================================================
    // Crossing into mclk
    logic [1:0] cs_sync_r;
    logic cs_q_r;
    logic [1:0] tog_sync_r;
    logic tog_q_r;
    logic cs_rise;
    logic tog_chg;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_sync_r <= 2'h3;
            cs_q_r <= 1'b1;
        end
        else
        begin
            cs_sync_r <= {cs_sync_r[0], chip_select_n};
            cs_q_r <= cs_sync_r[1];
        end
    end

    // The address word is stable well before its toggle gets through
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            tog_sync_r <= 2'h0;
            tog_q_r <= 1'b0;
        end
        else
        begin
            tog_sync_r <= {tog_sync_r[0], xfer.req_tog};
            tog_q_r <= tog_sync_r[1];
        end
    end

    assign cs_rise = cs_sync_r[1] & ~cs_q_r;
    assign tog_chg = tog_sync_r[1] ^ tog_q_r;

    // ==========================================================
    // Pending lockdown request, consumed by the select rising
    logic pend_r;
    logic [FSL_ADDR_W-1:0] pend_addr_r;
    logic [FSL_ADDR_W-1:0] req_addr;
    logic upd_start;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pend_r <= 1'b0;
        else if (tog_chg && !cs_rise)
            pend_r <= 1'b1;
        else if (cs_rise)
            pend_r <= 1'b0;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pend_addr_r <= 24'h000000;
        else if (tog_chg)
            pend_addr_r <= xfer.addr;
    end

    assign req_addr = tog_chg ? xfer.addr : pend_addr_r;

    // ==========================================================
    // Update sequencer; a request arriving while busy is dropped
    fsl_state_t st_r;
    fsl_state_t st_nxt;
    logic [TW-1:0] tmr_r;
    logic upd_done;
    logic [FSL_ADDR_W-1:0] tgt_addr_r;
    logic [SW-1:0] tgt_sect;
    logic tgt_sub;
    logic [7:0] status_r;

    assign upd_start = (st_r == FSL_IDLE) && cs_rise && (pend_r || tog_chg); // R10
    assign upd_done = (st_r == FSL_BUSY) && (tmr_r == TMR_LAST); // R10

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            FSL_IDLE:
            begin
                if (upd_start)
                    st_nxt = FSL_BUSY; // R10
            end
            FSL_BUSY:
            begin
                if (upd_done)
                    st_nxt = FSL_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st_r <= FSL_IDLE;
        else
            st_r <= st_nxt;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            tmr_r <= '0;
        else if (st_r == FSL_BUSY && !upd_done)
            tmr_r <= tmr_r + TW'(1); // R10
        else
            tmr_r <= '0;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            tgt_addr_r <= 24'h000000;
        else if (upd_start)
            tgt_addr_r <= req_addr; // R04
    end

    // Only the sector field and the subsector bit matter
    assign tgt_sect = tgt_addr_r[SECT_LSB +: SW]; // R08
    assign tgt_sub = tgt_addr_r[SUB0_BIT]; // R07

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            status_r <= FSL_STATUS_READY;
        else if (st_nxt == FSL_IDLE)
            status_r <= FSL_STATUS_READY; // R11
        else
            status_r <= FSL_STATUS_BUSY; // R11
    end

    assign status_byte = status_r;

    // ==========================================================
    // Lock store; reset stands in for the power-up load of the
    // nonvolatile bits, so a bench starts from all sectors open
    logic [NSECT-1:0] lk_r;
    logic lk0b_r;
    logic [NSECT:0] lk_all;
    // A net, so each generate branch may drive its own byte of it
    wire logic [8*NSECT-1:0] stat_w;

    for (genvar n = 0; n < NSECT; n++)
    begin : g_sect
        always_ff @(posedge mclk or negedge nrst)
        begin
            if (!nrst)
                lk_r[n] <= 1'b0;
            else if (upd_done && tgt_sect == SW'(n) && (n != 0 || !tgt_sub))
                lk_r[n] <= 1'b1; // R15
        end
        if (n == 0)
        begin : g_s0
            assign stat_w[7:0] = {lk_r[0] ? FSL_SUB_LOCKED : 2'h0, // R16
                lk0b_r ? FSL_SUB_LOCKED : 2'h0, FSL_SUB_UNUSED};
        end
        else
        begin : g_sn
            assign stat_w[8*n +: 8] = lk_r[n] ? FSL_SECT_LOCKED : FSL_SECT_OPEN; // R14 R13
            sect_byte_a: assert property (@(posedge mclk) disable iff (!nrst) // R14
                $rose(lk_r[n]) |-> ($past(tgt_sect) == SW'(n)
                && xfer.stat[8*n +: 8] == FSL_SECT_LOCKED))
                else $error("sector status byte malformed");
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            lk0b_r <= 1'b0;
        else if (upd_done && tgt_sect == SECT0 && tgt_sub)
            lk0b_r <= 1'b1; // R07
    end

    assign lk_all = {lk0b_r, lk_r};
    assign xfer.stat = stat_w;

    // ==========================================================
    // Array write gate: erase, program and unlock of locked space
    logic [SW-1:0] op_sect;
    logic op_locked;
    logic op_grant_r;
    logic op_refuse_r;

    assign op_sect = op_addr[SECT_LSB +: SW];
    assign op_locked = (op_sect == SECT0) ? (op_addr[SUB0_BIT] ? lk0b_r : lk_r[0])
        : lk_r[op_sect]; // R01

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            op_grant_r <= 1'b0;
            op_refuse_r <= 1'b0;
        end
        else
        begin
            op_grant_r <= op_req && !op_locked;
            op_refuse_r <= op_req && op_locked; // R01
        end
    end

    assign op_grant = op_grant_r;
    assign op_refuse = op_refuse_r;

    // ==========================================================
    // Checks
    sequence upd_begin_s;
        (st_r == FSL_IDLE) && cs_rise && (pend_r || tog_chg);
    endsequence

    sequence busy_run_s;
        (st_r == FSL_BUSY && !status_r[FSL_BUSY_BIT]) [*4];
    endsequence

    start_on_end_a: assert property (@(posedge mclk) disable iff (!nrst) // R10
        upd_begin_s |=> busy_run_s)
        else $error("update did not start on select rising");
    no_spont_a: assert property (@(posedge mclk) disable iff (!nrst) // R10
        (st_r == FSL_IDLE && !cs_rise) |=> st_r == FSL_IDLE)
        else $error("update started without select rising");
    busy_hold_a: assert property (@(posedge mclk) disable iff (!nrst) // R10
        (st_r == FSL_BUSY && tmr_r != TMR_LAST)
        |=> st_r == FSL_BUSY && tmr_r == $past(tmr_r) + TW'(1))
        else $error("update ended early");
    done_ready_a: assert property (@(posedge mclk) disable iff (!nrst) // R11
        upd_done |=> (st_r == FSL_IDLE && status_r == FSL_STATUS_READY))
        else $error("ready not shown after update");
    lock_sticky_a: assert property (@(posedge mclk) disable iff (!nrst) // R01
        ($past(lk_all) & ~lk_all) == '0)
        else $error("locked sector reopened");
    lock_source_a: assert property (@(posedge mclk) disable iff (!nrst) // R15
        $changed(lk_all) |-> $past(upd_done))
        else $error("lock changed outside an update");
    refuse_a: assert property (@(posedge mclk) disable iff (!nrst) // R01
        (op_req && op_locked) |=> (op_refuse && !op_grant))
        else $error("write to locked sector not refused");
    sub0b_a: assert property (@(posedge mclk) disable iff (!nrst) // R07
        (upd_done && tgt_sect == SECT0 && tgt_sub) |=> (lk0b_r && lk_r[0] == $past(lk_r[0])))
        else $error("subsector 0b lock misrouted");
    byte0_a: assert property (@(posedge mclk) disable iff (!nrst) // R16
        xfer.stat[3:0] == FSL_SUB_UNUSED && xfer.stat[7] == lk_r[0]
        && xfer.stat[6] == xfer.stat[7] && xfer.stat[5] == lk0b_r && xfer.stat[4] == xfer.stat[5])
        else $error("sector 0 status byte malformed");
endmodule

`default_nettype wire

//--- inc/fsl_pkg.sv
/*
 * Constants and types shared by the sector lockdown block.
 * Assumes a 50 MHz system clock and a serial link in mode 0 or 3.
 */
`default_nettype none

package fsl_pkg;
    // ==========================================================
    // Serial command set
    localparam logic [7:0] FSL_OP_LOCK_RD = 8'h35;
    localparam logic [31:0] FSL_CMD_LOCK_PGM = 32'h3D2A7F30;
    localparam int FSL_ADDR_W = 24;

    // ==========================================================
    // Bit counter marks within a frame
    localparam logic [7:0] FSL_CNT_OP_LAST = 8'h07;
    localparam logic [7:0] FSL_CNT_CMD_LAST = 8'h1F;
    localparam logic [7:0] FSL_CNT_ADDR_LAST = 8'h37;
    localparam logic [7:0] FSL_CNT_DATA_FIRST = 8'h20;
    localparam logic [7:0] FSL_CNT_MAX = 8'hFF;

    // ==========================================================
    // Lockdown status encodings
    localparam logic [7:0] FSL_SECT_LOCKED = 8'hFF;
    localparam logic [7:0] FSL_SECT_OPEN = 8'h00;
    localparam logic [1:0] FSL_SUB_LOCKED = 2'h3;
    localparam logic [3:0] FSL_SUB_UNUSED = 4'h0;
    localparam int FSL_BUSY_BIT = 7;
    localparam logic [7:0] FSL_STATUS_READY = 8'h80;
    localparam logic [7:0] FSL_STATUS_BUSY = 8'h00;

    // ==========================================================
    // Geometry and timing defaults
    localparam int FSL_NSECT_DEF = 16;
    localparam int FSL_SECT_LSB_DEF = 17;
    localparam int FSL_SUB0_BIT_DEF = 12;
    localparam int FSL_MCLK_PERIOD_NS = 20;
    localparam int FSL_PP_TIME_MS = 4;
    localparam int FSL_PP_CYCLES_DEF =
        (FSL_PP_TIME_MS * 1000000 + FSL_MCLK_PERIOD_NS - 1) / FSL_MCLK_PERIOD_NS;
    localparam int FSL_PP_CYCLES_MIN = 8;

    typedef enum logic {FSL_IDLE, FSL_BUSY} fsl_state_t;
endpackage

`default_nettype wire

//--- inc/fsl_xfer_if.sv
/*
 * Carrier between the serial front end and the lockdown core.
 * Assumes req_tog and addr come from the link clock domain, stat from the system one.
 */
`default_nettype none

interface fsl_xfer_if
    import fsl_pkg::*;
#(
    parameter int NSECT = FSL_NSECT_DEF
);
    logic req_tog;
    logic [FSL_ADDR_W-1:0] addr;
    logic [8*NSECT-1:0] stat;

    modport front (output req_tog, output addr, input stat);
    modport core (input req_tog, input addr, output stat);
endinterface

`default_nettype wire

//--- core/fsl_serial.sv
/*
 * Link side of the lockdown block: shifts commands in, shifts status out.
 * Assumes sclk runs only inside frames and chip_select_n high ends every frame.
 */
`default_nettype none

module fsl_serial
    import fsl_pkg::*;
#(
    parameter int NSECT = FSL_NSECT_DEF
)(
    input wire logic nrst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic miso,
    fsl_xfer_if.front lnk
);
    localparam int SW = $clog2(NSECT);

    logic [7:0] cnt_r;
    logic [31:0] sh_r;
    logic [31:0] sh_nxt;
    logic [FSL_ADDR_W-1:0] addr_in;
    logic rd_arm_r;
    logic lk_arm_r;
    logic req_tog_r;
    logic [FSL_ADDR_W-1:0] addr_r;
    logic miso_r;
    logic [7:0] idx;
    logic [SW+2:0] bitpos;

    // ==========================================================
    // Command intake; frame state is cleared by the frame's own select
    assign sh_nxt = {sh_r[30:0], mosi}; // R06
    assign addr_in = sh_nxt[FSL_ADDR_W-1:0];

    always_ff @(posedge sclk or posedge chip_select_n)
    begin
        if (chip_select_n)
            cnt_r <= 8'h00;
        else if (cnt_r != FSL_CNT_MAX)
            cnt_r <= cnt_r + 8'h01;
    end

    always_ff @(posedge sclk or posedge chip_select_n)
    begin
        if (chip_select_n)
            sh_r <= 32'h00000000;
        else
            sh_r <= sh_nxt; // R06
    end

    always_ff @(posedge sclk or posedge chip_select_n)
    begin
        if (chip_select_n)
            rd_arm_r <= 1'b0;
        else if (cnt_r == FSL_CNT_OP_LAST && sh_nxt[7:0] == FSL_OP_LOCK_RD)
            rd_arm_r <= 1'b1; // R02
    end

    always_ff @(posedge sclk or posedge chip_select_n)
    begin
        if (chip_select_n)
            lk_arm_r <= 1'b0;
        else if (cnt_r == FSL_CNT_CMD_LAST)
            lk_arm_r <= (sh_nxt == FSL_CMD_LOCK_PGM); // R03
    end

    // Address and toggle outlive the frame so the core can pick them up
    always_ff @(posedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            req_tog_r <= 1'b0;
            addr_r <= 24'h000000;
        end
        else if (lk_arm_r && cnt_r == FSL_CNT_ADDR_LAST)
        begin
            addr_r <= addr_in; // R04
            req_tog_r <= ~req_tog_r;
        end
    end

    assign lnk.req_tog = req_tog_r;
    assign lnk.addr = addr_r;

    // ==========================================================
    // Status out; stat changes only at the end of an update, so it is
    // quasi-static here, and a read overlapping an update may see either value
    assign idx = cnt_r - FSL_CNT_DATA_FIRST;
    assign bitpos = {idx[3 +: SW], ~idx[2:0]}; // R18

    always_ff @(negedge sclk or posedge chip_select_n)
    begin
        if (chip_select_n)
            miso_r <= 1'b0;
        else if (rd_arm_r && cnt_r >= FSL_CNT_DATA_FIRST) // R17
            miso_r <= lnk.stat[bitpos]; // R18
        else
            miso_r <= 1'b0;
    end

    assign miso = miso_r;

    // ==========================================================
    // Checks
    rd_decode_a: assert property (@(posedge sclk) disable iff (chip_select_n) // R02
        (cnt_r == FSL_CNT_OP_LAST && sh_nxt[7:0] == FSL_OP_LOCK_RD) |=> rd_arm_r [*8])
        else $error("read opcode not armed");
    lk_reject_a: assert property (@(posedge sclk) disable iff (chip_select_n) // R03
        (cnt_r == FSL_CNT_CMD_LAST && sh_nxt != FSL_CMD_LOCK_PGM) |=> !lk_arm_r)
        else $error("wrong lockdown sequence armed");
    miso_quiet_a: assert property (@(posedge sclk) disable iff (chip_select_n) // R17
        (!rd_arm_r || cnt_r < FSL_CNT_DATA_FIRST) |-> !miso_r)
        else $error("data out before status phase");
endmodule

`default_nettype wire

//--- testbench/fsl_master_model.sv
/*
 * Behavioural serial master that stands in for the user logic on the link.
 * Assumes the lockdown block samples on sclk rising and shifts out on falling.
 */
`default_nettype none

module fsl_master_model (
    output logic sclk,
    output logic chip_select_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Link timing, 64 ns period
    localparam time HALF = 32;

    // Clock idles high and stands still between frames
    initial
    begin
        sclk = 1'b1;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end

    // ==========================================================
    // One frame: nbits sent from dout[255] downward, miso gathered into din
    task automatic xfer(input int nbits, input logic [255:0] dout, output logic [255:0] din);
        din = '0;
        // Odd offset keeps link edges away from the system clock edges
        #13;
        chip_select_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            #HALF;
            sclk = 1'b0;
            mosi = dout[255 - i];
            #HALF;
            sclk = 1'b1;
            din = {din[254:0], miso};
        end
        #HALF;
        sclk = 1'b0;
        #HALF;
        chip_select_n = 1'b1;
        // Released line must not keep showing the last bit
        mosi = ~mosi;
        #HALF;
        sclk = 1'b1;
    endtask
endmodule

`default_nettype wire

//--- testbench/test_fsl_lockdown.sv
/*
 * Self-checking bench for the sector lockdown block: serial frames, status, array gate.
 * Assumes fsl_pkg and the master model are compiled first.
 */
`default_nettype none

module test_fsl_lockdown;
    import fsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Set-up; update time shortened so the run stays brief
    localparam int PP = 16;
    localparam int NS = 16;
    localparam int TMO = 30000;

    logic mclk, nrst, sclk, chip_select_n, mosi, miso;
    logic op_req, op_grant, op_refuse;
    logic [FSL_ADDR_W-1:0] op_addr;
    logic [7:0] status_byte;
    logic [7:0] exp_lock [NS];
    logic [31:0] bad_cmd [4];
    int fail_count, n_checks, cyc;

    fsl_lockdown #(.NSECT(NS), .PP_CYCLES(PP)) dut (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n),
        .mosi(mosi), .miso(miso), .op_req(op_req), .op_addr(op_addr),
        .op_grant(op_grant), .op_refuse(op_refuse), .status_byte(status_byte)
    );

    fsl_master_model master (
        .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso)
    );

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == TMO)
        begin
            fail_count++;
            $display("MISMATCH %0t timeout", $time);
            print_verdict();
        end
    end

    // ==========================================================
    // Compare and closing tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        n_checks++;
        if (got != exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // Address in sector s; page and byte bits deliberately non-zero
    function automatic logic [23:0] sa(input int s, input logic sub);
        return 24'hA00ABC | (24'(s) << 17) | (24'(sub) << 12);
    endfunction

    // Array attempt; the answer stands for the one cycle after the request
    task automatic gate(input logic [23:0] a, input logic locked);
        @(negedge mclk);
        op_req = 1'b1;
        op_addr = a;
        @(negedge mclk);
        chk8({6'h0, op_grant, op_refuse}, locked ? 8'h01 : 8'h02, "array gate");
        op_req = 1'b0;
        op_addr = ~a;
    endtask

    // Lockdown frame, then the busy window is measured on status_byte
    task automatic lock_frame(input logic [31:0] cmd, input logic [23:0] a, input logic busy);
        logic [255:0] d;
        int w;
        int n;
        master.xfer(56, {cmd, a, 200'h0}, d);
        w = 0;
        n = 0;
        while (status_byte !== FSL_STATUS_BUSY && w < 8)
        begin
            @(negedge mclk);
            w++;
        end
        while (status_byte === FSL_STATUS_BUSY && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        chk_cnt(int'(w < 7), int'(busy), "busy start");
        chk_cnt(n, busy ? PP : 0, "busy length");
        chk8(status_byte, FSL_STATUS_READY, "ready after frame");
    endtask

    // Register read; dummy and trailing mosi bits are non-zero on purpose
    task automatic read_check(input logic [7:0] op);
        logic [255:0] d;
        master.xfer(32 + 8 * NS, {op, 24'hA5A5A5, {224{1'b1}}}, d);
        for (int s = 0; s < NS; s++)
            chk8(d[8*NS-1-8*s -: 8], op == FSL_OP_LOCK_RD ? exp_lock[s] : 8'h00,
                "lock byte");
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        op_req = 1'b0;
        op_addr = '0;
        fail_count = 0;
        n_checks = 0;
        cyc = 0;
        bad_cmd = '{32'h3D2A7F31, 32'h3C2A7F30, 32'h302A7F3D, 32'hBC54FE0C};
        foreach (exp_lock[i])
            exp_lock[i] = FSL_SECT_OPEN;
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        chk8(status_byte, FSL_STATUS_READY, "ready after reset");
        read_check(FSL_OP_LOCK_RD);
        gate(sa(5, 1'b0), 1'b0);
        lock_frame(FSL_CMD_LOCK_PGM, sa(5, 1'b0), 1'b1);
        exp_lock[5] = FSL_SECT_LOCKED;
        read_check(FSL_OP_LOCK_RD);
        gate(sa(5, 1'b1), 1'b1);
        gate(sa(6, 1'b0), 1'b0);
        foreach (bad_cmd[i])
            lock_frame(bad_cmd[i], sa(7, 1'b0), 1'b0);
        lock_frame(FSL_CMD_LOCK_PGM, sa(0, 1'b0), 1'b1);
        exp_lock[0] = 8'hC0;
        read_check(FSL_OP_LOCK_RD);
        gate(sa(0, 1'b0), 1'b1);
        gate(sa(0, 1'b1), 1'b0);
        lock_frame(FSL_CMD_LOCK_PGM, sa(0, 1'b1), 1'b1);
        exp_lock[0] = 8'hF0;
        gate(sa(0, 1'b1), 1'b1);
        lock_frame(FSL_CMD_LOCK_PGM, sa(15, 1'b1), 1'b1);
        exp_lock[15] = FSL_SECT_LOCKED;
        read_check(8'h32);
        read_check(FSL_OP_LOCK_RD);
        gate(sa(15, 1'b0), 1'b1);
        print_verdict();
    end
endmodule

`default_nettype wire
